// ===== frq_defines.svh
`ifndef FRQ_DEFINES_SVH
`define FRQ_DEFINES_SVH

// ---------------------------------------------------------------
// Clock and timing
// ---------------------------------------------------------------
`define FRQ_CLK_HZ          10000000
`define FRQ_DELAY_UNIT_S    0.001
`define FRQ_MS_CYC          (`FRQ_CLK_HZ / 1000)
`define FRQ_FORCE_TMO_S     300
`define FRQ_FORCE_TMO_CYC   (64'd300 * 64'd10000000)

// ---------------------------------------------------------------
// Register byte addresses, address width and region codes
// ---------------------------------------------------------------
`define FRQ_CTRL_ADDR       12'h000
`define FRQ_BANKSEL_ADDR    12'h004
`define FRQ_LVBLK_ADDR      12'h008
`define FRQ_STATUS_ADDR     12'h00c
`define FRQ_FREQ_ADDR       12'h010
`define FRQ_INT_STAT_ADDR   12'h014
`define FRQ_INT_MASK_ADDR   12'h018
`define FRQ_FLT_PTR_ADDR    12'h01c
`define FRQ_REG_ADDR_W      12
`define FRQ_RGN_CTRL        6'h00
`define FRQ_RGN_PICKUP      6'h01
`define FRQ_RGN_DELAY       6'h02
`define FRQ_RGN_COUNT       6'h03
`define FRQ_RGN_FAULT       5'h02

// ---------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------
`define FRQ_CTRL_FORCE      0
`define FRQ_CTRL_MODE_LO    1
`define FRQ_CTRL_SCLR_LO    8
`define FRQ_CTRL_TCLR_LO    12
`define FRQ_BS_MAN_LO       0
`define FRQ_BS_ALT_LO       2
`define FRQ_BS_SRC_LO       4
`define FRQ_BS_IDX_LO       7
`define FRQ_BS_ACT_LO       10

// ---------------------------------------------------------------
// Bank select source codes
// ---------------------------------------------------------------
`define FRQ_SRC_NONE        3'h0
`define FRQ_SRC_DI          3'h1
`define FRQ_SRC_VI          3'h2
`define FRQ_SRC_LED         3'h3
`define FRQ_SRC_VO          3'h4

// ---------------------------------------------------------------
// Reset values and trip percent
// ---------------------------------------------------------------
`define FRQ_PICKUP_RST      16'h1388
`define FRQ_DELAY_RST       16'h0064
`define FRQ_LVBLK_RST       8'h0a
`define FRQ_PCT_TRIP        8'h64

`endif

// ===== frq_pkg.sv
package frq_pkg;

    typedef enum logic [2:0] {
        FRQ_IDLE  = 3'b001,
        FRQ_START = 3'b010,
        FRQ_TRIP  = 3'b100
    } frq_state_t;

    typedef logic [15:0] frq_word_t;

endpackage

// ===== frq_protection.sv
`timescale 1ns/100ps
`include "frq_defines.svh"

// Overview of operation
// [RL1] Measure frequency only with voltage present
// [RL2] Start when frequency crosses stage pick-up
// [RL3] Trip when start outlasts operate delay
// [RL4] Hold adapted frequency without any voltage
// [RL5] Stages one and two select over/under
// [RL6] Block underfrequency below common voltage limit
// [RL7] Stay blocked until pick-up is reached
// [RL8] Four stages, two configurable, two under
// [RL9] Definite operate delay per stage
// [RL10] Four settings banks, selectable active bank
// [RL11] Bank select source: none/DI/VI/LED/VO
// [RL12] Status blocked/start/trip, writable under force; only start and trip are forced, blocked is not
// [RL13] Start and trip counters, clearable
// [RL14] Common force flag, five-minute timeout
// [RL15] Operator password before editing settings; not checked in this block, left to the host software
// [RL16] Keep latest eight fault records
// [RL17] Elapsed delay as percent, 100 is trip
// [RL18] Start drops and timer resets on return
// [RL19] Ninth fault overwrites oldest record
module frq_protection
    import frq_pkg::*;
#(
    parameter logic [63:0] FORCE_TMO_CYC = `FRQ_FORCE_TMO_CYC
) (
    input  wire logic        mclk_in,
    input  wire logic        rst_in,
    input  wire logic        psel_in,
    input  wire logic        penable_in,
    input  wire logic        pwrite_in,
    input  wire logic [11:0] paddr_in,
    input  wire logic [31:0] pwdata_in,
    output logic      [31:0] prdata_out,
    output logic             pready_out,
    output logic             pslverr_out,
    input  wire logic [15:0] freq_in,
    input  wire logic        volt1_present_in,
    input  wire logic        volt2_present_in,
    input  wire logic [7:0]  ull_max_pct_in,
    input  wire logic [31:0] rtc_date_in,
    input  wire logic [31:0] rtc_time_in,
    input  wire logic [7:0]  digital_input_n_in,
    input  wire logic [7:0]  virtual_input_n_in,
    input  wire logic [7:0]  indicator_led_n_in,
    input  wire logic [7:0]  virtual_output_n_in,
    output logic      [3:0]  start_out,
    output logic      [3:0]  trip_out,
    output logic      [3:0]  blocked_out,
    output logic      [1:0]  active_settings_bank_out,
    output logic             force_out,
    output logic             irq_out
);

    // ---------------------------------------------------------------
    // Pin synchronisers
    // ---------------------------------------------------------------
    logic [33:0] sync1_ff;
    logic [33:0] sync2_ff;
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            sync1_ff <= 34'h0;
            sync2_ff <= 34'h0;
        end else begin
            sync1_ff <= {volt2_present_in, volt1_present_in, virtual_output_n_in,
                         indicator_led_n_in, virtual_input_n_in, digital_input_n_in};
            sync2_ff <= sync1_ff;
        end
    end
    wire logic       volt_any = sync2_ff[33] | sync2_ff[32];
    wire logic [7:0] di_s     = sync2_ff[7:0];
    wire logic [7:0] vi_s     = sync2_ff[15:8];
    wire logic [7:0] led_s    = sync2_ff[23:16];
    wire logic [7:0] vo_s     = sync2_ff[31:24];

    // ---------------------------------------------------------------
    // Registers and APB decode
    // ---------------------------------------------------------------
    logic        force_ff;
    logic [1:0]  under_sel_ff;
    logic [9:0]  banksel_ff;
    logic [7:0]  lvblk_ff;
    logic [7:0]  int_stat_ff;
    logic [7:0]  int_mask_ff;
    frq_word_t   pickup_ff [16];
    frq_word_t   delay_ff  [16];
    logic [15:0] scnt_ff   [4];
    logic [15:0] tcnt_ff   [4];
    logic [31:0] fdate_ff  [8];
    logic [31:0] ftime_ff  [8];
    logic [31:0] finfo_ff  [8];
    logic [2:0]  fptr_ff;
    logic [3:0]  fnum_ff;
    logic [3:0]  frc_start_ff;
    logic [3:0]  frc_trip_ff;
    logic [3:0]  frc_on_ff;
    logic [15:0] freq_ff;
    logic        adapted_ff;
    logic [1:0]  bank_ff;
    logic [63:0] force_cnt_ff;
    logic [31:0] rdata;

    wire logic       setup   = psel_in & ~penable_in;
    wire logic       acc     = psel_in & penable_in & pready_out;
    wire logic       wr      = acc & pwrite_in;
    wire logic       rd      = acc & ~pwrite_in;
    wire logic [5:0] rgn     = paddr_in[11:6];
    wire logic [3:0] rix     = paddr_in[5:2];
    wire logic       in_ctrl = (rgn == `FRQ_RGN_CTRL) & ~rix[3];
    wire logic       in_pick = (rgn == `FRQ_RGN_PICKUP);
    wire logic       in_dly  = (rgn == `FRQ_RGN_DELAY);
    wire logic       in_cnt  = (rgn == `FRQ_RGN_COUNT) & ~rix[3];
    wire logic       in_flt  = (paddr_in[11:7] == `FRQ_RGN_FAULT);
    wire logic       mapped  = in_ctrl | in_pick | in_dly | in_cnt | in_flt;
    wire logic       wr_ctrl = wr & (paddr_in == `FRQ_CTRL_ADDR);
    wire logic       wr_stat = wr & (paddr_in == `FRQ_STATUS_ADDR);
    wire logic       rd_int  = rd & (paddr_in == `FRQ_INT_STAT_ADDR);
    wire logic [3:0] sclr    = wr_ctrl ? pwdata_in[`FRQ_CTRL_SCLR_LO +: 4] : 4'h0;
    wire logic [3:0] tclr    = wr_ctrl ? pwdata_in[`FRQ_CTRL_TCLR_LO +: 4] : 4'h0;
    wire logic [2:0] frec    = paddr_in[6:4];

    always_comb begin
        rdata = 32'h0;
        if (in_ctrl) begin
            case (paddr_in)
                `FRQ_CTRL_ADDR:     rdata = {29'h0, under_sel_ff, force_ff};
                `FRQ_BANKSEL_ADDR:  rdata = {20'h0, bank_ff, banksel_ff};
                `FRQ_LVBLK_ADDR:    rdata = {24'h0, lvblk_ff};
                `FRQ_STATUS_ADDR: begin
                    for (int i = 0; i < 4; i++) begin
                        rdata[i*4 +: 3] = {trip_out[i], start_out[i], blocked_out[i]};
                    end
                end
                `FRQ_FREQ_ADDR:     rdata = {15'h0, adapted_ff, freq_ff};
                `FRQ_INT_STAT_ADDR: rdata = {24'h0, int_stat_ff};
                `FRQ_INT_MASK_ADDR: rdata = {24'h0, int_mask_ff};
                `FRQ_FLT_PTR_ADDR:  rdata = {24'h0, fnum_ff, 1'b0, fptr_ff};
                default:            rdata = 32'h0;
            endcase
        end else if (in_pick) begin
            rdata = {16'h0, pickup_ff[rix]};
        end else if (in_dly) begin
            rdata = {16'h0, delay_ff[rix]};
        end else if (in_cnt) begin
            rdata = {16'h0, rix[2] ? tcnt_ff[rix[1:0]] : scnt_ff[rix[1:0]]};
        end else if (in_flt) begin
            case (paddr_in[3:2])
                2'h0:    rdata = fdate_ff[frec];
                2'h1:    rdata = ftime_ff[frec];
                2'h2:    rdata = finfo_ff[frec];
                default: rdata = 32'h0;
            endcase
        end
    end

    // Answer in the access cycle right after setup; data is latched at setup.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            pready_out  <= 1'b0;
            prdata_out  <= 32'h0;
            pslverr_out <= 1'b0;
        end else begin
            pready_out  <= setup;
            prdata_out  <= setup ? rdata : 32'h0;
            pslverr_out <= setup & ~mapped;
        end
    end

    // [RL15] Editable settings. Password checking lives in the host software.
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            under_sel_ff <= 2'h0;
            banksel_ff   <= 10'h0;
            lvblk_ff     <= `FRQ_LVBLK_RST;
            int_mask_ff  <= 8'h0;
            for (int i = 0; i < 16; i++) begin
                pickup_ff[i] <= `FRQ_PICKUP_RST;
                delay_ff[i]  <= `FRQ_DELAY_RST;
            end
        end else if (wr) begin
            case (paddr_in)
                // [RL5] Over/under selection
                `FRQ_CTRL_ADDR:     under_sel_ff <= pwdata_in[`FRQ_CTRL_MODE_LO +: 2];
                `FRQ_BANKSEL_ADDR:  banksel_ff   <= pwdata_in[9:0];
                `FRQ_LVBLK_ADDR:    lvblk_ff     <= pwdata_in[7:0];
                `FRQ_INT_MASK_ADDR: int_mask_ff  <= pwdata_in[7:0];
                default: begin
                    if (in_pick) begin
                        pickup_ff[rix] <= pwdata_in[15:0];
                    end
                    if (in_dly) begin
                        delay_ff[rix] <= pwdata_in[15:0];
                    end
                end
            endcase
        end
    end

    // ---------------------------------------------------------------
    // Force flag and forced status
    // ---------------------------------------------------------------
    wire logic force_tmo = force_ff & (force_cnt_ff >= FORCE_TMO_CYC - 64'd1);
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            force_ff     <= 1'b0;
            force_cnt_ff <= 64'h0;
            frc_start_ff <= 4'h0;
            frc_trip_ff  <= 4'h0;
            frc_on_ff    <= 4'h0;
        end else begin
            // [RL14] Force with timeout
            if (wr_ctrl) begin
                force_ff     <= pwdata_in[`FRQ_CTRL_FORCE];
                force_cnt_ff <= 64'h0;
            end else if (force_tmo) begin
                force_ff     <= 1'b0;
            end else if (force_ff) begin
                force_cnt_ff <= force_cnt_ff + 64'd1;
            end
            // [RL12] Status write needs force
            if (!force_ff) begin
                frc_on_ff <= 4'h0;
            end else if (wr_stat) begin
                frc_on_ff <= 4'hf;
                for (int i = 0; i < 4; i++) begin
                    frc_start_ff[i] <= pwdata_in[i*4 + 1];
                    frc_trip_ff[i]  <= pwdata_in[i*4 + 2];
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Frequency source and settings bank
    // ---------------------------------------------------------------
    wire logic [2:0] src     = banksel_ff[`FRQ_BS_SRC_LO +: 3];
    wire logic [2:0] sidx    = banksel_ff[`FRQ_BS_IDX_LO +: 3];
    // [RL11] Bank source select
    wire logic       src_lvl = (src == `FRQ_SRC_DI)  ? di_s[sidx]  :
                               (src == `FRQ_SRC_VI)  ? vi_s[sidx]  :
                               (src == `FRQ_SRC_LED) ? led_s[sidx] :
                               (src == `FRQ_SRC_VO)  ? vo_s[sidx]  : 1'b0;
    // [RL10] Active bank choice
    wire logic [1:0] nxt_bank = src_lvl ? banksel_ff[`FRQ_BS_ALT_LO +: 2]
                                        : banksel_ff[`FRQ_BS_MAN_LO +: 2];
    logic [13:0] pre_ff;
    wire logic   ms_tick = (pre_ff == 14'(`FRQ_MS_CYC - 1));
    wire logic   lv_low  = ull_max_pct_in < lvblk_ff;

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            freq_ff    <= 16'h0;
            adapted_ff <= 1'b1;
            bank_ff    <= 2'h0;
            pre_ff     <= 14'h0;
        end else begin
            // [RL1] Measure only with voltage
            if (volt_any) begin
                freq_ff <= freq_in;
            end
            // [RL4] Adapted value held
            adapted_ff <= ~volt_any;
            bank_ff    <= nxt_bank;
            pre_ff     <= ms_tick ? 14'h0 : pre_ff + 14'h1;
        end
    end

    // ---------------------------------------------------------------
    // Four stages
    // ---------------------------------------------------------------
    // [RL8] Four stages, two fixed under
    logic [3:0]  st_start;
    logic [3:0]  st_trip;
    logic [3:0]  st_blk;
    logic [3:0]  ended;
    logic [15:0] elapsed [4];
    genvar s;
    generate
        for (s = 0; s < 4; s++) begin : g_stage
            frq_state_t  state_ff;
            frq_state_t  nxt_state;
            logic [15:0] el_ff;
            logic        latch_ff;
            wire logic [3:0] sel   = {2'(s), bank_ff};
            wire logic [15:0] pk   = pickup_ff[sel];
            wire logic [15:0] dl   = delay_ff[sel];
            wire logic   under     = (s >= 2) ? 1'b1 : under_sel_ff[s % 2];
            // [RL2] Direction-aware pick-up
            wire logic   pick      = under ? (freq_ff < pk) : (freq_ff > pk);
            // [RL6] [RL7] Voltage self blocking
            wire logic   blk       = under & (lv_low | latch_ff);
            wire logic   cond      = pick & ~blk;

            always_comb begin
                case (state_ff)
                    FRQ_IDLE:  nxt_state = cond ? FRQ_START : FRQ_IDLE;
                    // [RL3] [RL9] Definite delay elapsed
                    FRQ_START: nxt_state = !cond ? FRQ_IDLE :
                                           (el_ff > dl) ? FRQ_TRIP : FRQ_START;
                    FRQ_TRIP:  nxt_state = cond ? FRQ_TRIP : FRQ_IDLE;
                    default:   nxt_state = FRQ_IDLE;
                endcase
            end

            always_ff @(posedge mclk_in or posedge rst_in) begin
                if (rst_in) begin
                    state_ff <= FRQ_IDLE;
                    el_ff    <= 16'h0;
                    latch_ff <= 1'b1;
                end else begin
                    state_ff <= nxt_state;
                    // [RL18] Timer restarts on return
                    if (!cond) begin
                        el_ff <= 16'h0;
                    end else if (ms_tick && el_ff != 16'hffff) begin
                        el_ff <= el_ff + 16'h1;
                    end
                    if (lv_low) begin
                        latch_ff <= 1'b1;
                    end else if (freq_ff >= pk) begin
                        latch_ff <= 1'b0;
                    end
                end
            end

            assign st_start[s] = (nxt_state != FRQ_IDLE);
            assign st_trip[s]  = (nxt_state == FRQ_TRIP);
            assign st_blk[s]   = blk;
            assign ended[s]    = (state_ff != FRQ_IDLE) & (nxt_state == FRQ_IDLE);
            assign elapsed[s]  = el_ff;
        end
    endgenerate

    wire logic [3:0] nxt_start = force_ff & frc_on_ff[0] ? frc_start_ff : st_start;
    wire logic [3:0] nxt_trip  = force_ff & frc_on_ff[0] ? frc_trip_ff  : st_trip;
    wire logic [3:0] start_up  = nxt_start & ~start_out;
    wire logic [3:0] trip_up   = nxt_trip  & ~trip_out;

    // ---------------------------------------------------------------
    // Outputs, counters and interrupt
    // ---------------------------------------------------------------
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            start_out                <= 4'h0;
            trip_out                 <= 4'h0;
            blocked_out              <= 4'h0;
            active_settings_bank_out <= 2'h0;
            force_out                <= 1'b0;
            irq_out                  <= 1'b0;
            int_stat_ff              <= 8'h0;
            for (int i = 0; i < 4; i++) begin
                scnt_ff[i] <= 16'h0;
                tcnt_ff[i] <= 16'h0;
            end
        end else begin
            // [RL12] Reported status
            start_out                <= nxt_start;
            trip_out                 <= nxt_trip;
            blocked_out              <= st_blk;
            active_settings_bank_out <= nxt_bank;
            force_out                <= force_ff;
            irq_out                  <= |(int_stat_ff & int_mask_ff);
            // A new event in the clearing read survives it.
            int_stat_ff <= (rd_int ? 8'h0 : int_stat_ff) | {trip_up, start_up};
            // [RL13] Counters, clear with a new edge loads one
            for (int i = 0; i < 4; i++) begin
                if (start_up[i]) begin
                    scnt_ff[i] <= sclr[i] ? 16'h1 : scnt_ff[i] + 16'h1;
                end else if (sclr[i]) begin
                    scnt_ff[i] <= 16'h0;
                end
                if (trip_up[i]) begin
                    tcnt_ff[i] <= tclr[i] ? 16'h1 : tcnt_ff[i] + 16'h1;
                end else if (tclr[i]) begin
                    tcnt_ff[i] <= 16'h0;
                end
            end
        end
    end

    // ---------------------------------------------------------------
    // Fault log
    // ---------------------------------------------------------------
    // Two stages ending in the same cycle log only the lower one.
    wire logic [1:0]  fst    = ended[0] ? 2'd0 : ended[1] ? 2'd1 : ended[2] ? 2'd2 : 2'd3;
    wire logic [15:0] fdl    = delay_ff[{fst, bank_ff}];
    wire logic [22:0] fprod  = 23'(elapsed[fst]) * 23'd100;
    wire logic [22:0] fquot  = (fdl == 16'h0) ? 23'(`FRQ_PCT_TRIP) : fprod / 23'(fdl);
    // [RL17] Elapsed delay percent
    wire logic [7:0]  fpct   = (state_ff_trip(fst) || fquot >= 23'(`FRQ_PCT_TRIP))
                               ? `FRQ_PCT_TRIP : fquot[7:0];

    function automatic logic state_ff_trip(input logic [1:0] idx);
        state_ff_trip = trip_out[idx];
    endfunction

    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            fptr_ff <= 3'h0;
            fnum_ff <= 4'h0;
            for (int i = 0; i < 8; i++) begin
                fdate_ff[i] <= 32'h0;
                ftime_ff[i] <= 32'h0;
                finfo_ff[i] <= 32'h0;
            end
        end else if (|ended) begin
            // [RL16] [RL19] Ring of eight records
            fdate_ff[fptr_ff] <= rtc_date_in;
            ftime_ff[fptr_ff] <= rtc_time_in;
            finfo_ff[fptr_ff] <= {2'h0, fst, 2'h0, bank_ff, fpct, freq_ff};
            fptr_ff           <= fptr_ff + 3'h1;
            if (fnum_ff != 4'h8) begin
                fnum_ff <= fnum_ff + 4'h1;
            end
        end
    end

endmodule

// ===== frq_protection_sva.sv
`timescale 1ns/100ps
module frq_protection_sva
#(
    parameter logic [63:0] FORCE_TMO_CYC = 64'd200
) (
    input wire logic        mclk_in,
    input wire logic        rst_in,
    input wire logic        psel_in,
    input wire logic        penable_in,
    input wire logic        pwrite_in,
    input wire logic [11:0] paddr_in,
    input wire logic [31:0] prdata_out,
    input wire logic        pready_out,
    input wire logic        pslverr_out,
    input wire logic [3:0]  start_out,
    input wire logic [3:0]  trip_out,
    input wire logic [3:0]  blocked_out,
    input wire logic        force_out
);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (rst_in);
    // A control write restarts the force timeout, so it restarts the age too.
    logic [63:0] age_ff;
    wire         ctl_wr = psel_in & penable_in & pwrite_in & (paddr_in == 12'h000);
    always_ff @(posedge mclk_in or posedge rst_in) begin
        if (rst_in) begin
            age_ff <= 64'h0;
        end else begin
            age_ff <= (force_out & !ctl_wr) ? age_ff + 64'h1 : 64'h0;
        end
    end
    a_ready_setup: assert property (psel_in & !penable_in |=> pready_out)
        else $error("no pready after setup");
    a_ready_once: assert property (pready_out |=> !pready_out)
        else $error("pready held");
    a_err_ready: assert property (pslverr_out |-> pready_out)
        else $error("pslverr without pready");
    a_rdata_idle: assert property (!pready_out |-> prdata_out == 32'h0)
        else $error("read data outside access");
    a_trip_start: assert property ($rose(trip_out[0]) & !force_out
        |-> $past(start_out[0])) else $error("trip without start");
    a_drop_clear: assert property ($fell(start_out[0]) & !force_out
        & !$past(force_out) |-> !trip_out[0]) else $error("trip outlived start");
    a_block_quiet: assert property (!force_out & !$past(force_out)
        |-> (blocked_out & $past(blocked_out) & start_out) == 4'h0)
        else $error("start while blocked");
    a_force_tmo: assert property (age_ff <= FORCE_TMO_CYC + 64'd4)
        else $error("force outlived timeout");
    c_trip: cover property ($rose(trip_out[0]));
    c_block: cover property ($rose(blocked_out[2]));
    c_force: cover property ($fell(force_out));
endmodule
bind frq_protection frq_protection_sva #(.FORCE_TMO_CYC(FORCE_TMO_CYC)) u_sva (.*);

// ===== frq_front_model.sv
`timescale 1ns/100ps
module frq_front_model (
    input  wire logic        mclk_in,
    input  wire logic [15:0] set_freq_in,
    input  wire logic [7:0]  set_ull_in,
    input  wire logic [1:0]  set_volt_in,
    output logic      [15:0] freq_out,
    output logic      [7:0]  ull_out,
    output logic      [1:0]  volt_out
);
    logic [7:0] hist_ff;
    // ------------------------------------------
    // Measurement
    // ------------------------------------------
    // The word stays valid four cycles after voltage goes, then it toggles,
    // so only a value held inside the block can read steady.
    always_ff @(posedge mclk_in) begin
        hist_ff  <= {hist_ff[5:0], set_volt_in};
        volt_out <= set_volt_in;
        ull_out  <= set_ull_in;
        freq_out <= (|hist_ff) ? set_freq_in : ~freq_out;
    end
endmodule

// ===== frq_protection_tb.sv
`timescale 1ns/100ps
module frq_protection_tb;
    logic        mclk_in = 1'b0;
    logic        rst_in  = 1'b1;
    logic        psel    = 1'b0;
    logic        pen     = 1'b0;
    logic        pwr     = 1'b0;
    logic [11:0] paddr   = 12'h0;
    logic [31:0] pwdata  = 32'h0;
    logic [31:0] sel     = 32'h0;
    logic [15:0] set_f   = 16'd4900;
    logic [7:0]  set_u   = 8'd100;
    logic [1:0]  set_v   = 2'b11;
    logic [31:0] prdata, rd;
    logic [15:0] freq;
    logic [7:0]  ull;
    logic [3:0]  start, trip, blocked;
    logic [1:0]  volt, bank;
    logic        pready, pslverr, err_s, force_f, irq;
    int          bad_count = 0;
    int          checks    = 0;
    wire  [13:0] flags = {irq, force_f, blocked, trip, start};
    always #50 mclk_in = ~mclk_in;
    frq_front_model fe (.mclk_in(mclk_in), .set_freq_in(set_f), .set_ull_in(set_u),
        .set_volt_in(set_v), .freq_out(freq), .ull_out(ull), .volt_out(volt));
    frq_protection #(.FORCE_TMO_CYC(64'd200)) dut (.mclk_in(mclk_in), .rst_in(rst_in),
        .psel_in(psel), .penable_in(pen), .pwrite_in(pwr), .paddr_in(paddr),
        .pwdata_in(pwdata), .prdata_out(prdata), .pready_out(pready),
        .pslverr_out(pslverr), .freq_in(freq), .volt1_present_in(volt[0]),
        .volt2_present_in(volt[1]), .ull_max_pct_in(ull), .rtc_date_in({16'h0, set_f}),
        .rtc_time_in({24'h0, set_u}), .digital_input_n_in(sel[7:0]),
        .virtual_input_n_in(sel[15:8]), .indicator_led_n_in(sel[23:16]),
        .virtual_output_n_in(sel[31:24]), .start_out(start), .trip_out(trip),
        .blocked_out(blocked), .active_settings_bank_out(bank),
        .force_out(force_f), .irq_out(irq));
    task automatic results();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] e);
        checks++;
        if (got !== e) begin
            bad_count++;
            $display("[FAIL] %0t got %h exp %h", $time, got, e);
        end
    endtask
    task automatic wt(input int i, input logic v, input int lim);
        int n = 0;
        while (flags[i] !== v && n < lim) begin
            n++;
            @(posedge mclk_in);
        end
        chk(n < lim, 32'h1);
        if (n >= lim) results();
    endtask
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d);
        int n = 0;
        psel   <= 1'b1;
        pwr    <= w;
        paddr  <= a;
        pwdata <= d;
        @(posedge mclk_in);
        pen <= 1'b1;
        @(posedge mclk_in);
        while (pready !== 1'b1 && n < 20) begin
            n++;
            @(posedge mclk_in);
        end
        chk(n < 20, 32'h1);
        if (n >= 20) results();
        rd    = prdata;
        err_s = pslverr;
        psel <= 1'b0;
        pen  <= 1'b0;
        @(posedge mclk_in);
    endtask
    task automatic rdc(input logic [11:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        chk(rd, e);
    endtask
    initial begin
        repeat (10) @(posedge mclk_in);
        rst_in <= 1'b0;
        repeat (4) @(posedge mclk_in);
        rdc(12'h008, 32'h0000000a);
        rdc(12'h040, 32'h00001388);
        rdc(12'h0bc, 32'h00000064);
        rdc(12'hffc, 32'h0);
        chk(err_s, 32'h1);
        chk({start, blocked}, 32'h0c);
        apb(1'b1, 12'h080, 32'h0);
        apb(1'b1, 12'h018, 32'h1);
        apb(1'b1, 12'h00c, 32'h6);
        apb(1'b0, 12'h014, 32'h0);
        chk(trip, 32'h0);
        set_f <= 16'd5100;
        wt(0, 1'b1, 20);
        wt(13, 1'b1, 5);
        wt(10, 1'b0, 5);
        wt(4, 1'b1, 25000);
        chk(trip, 32'h1);
        rdc(12'h014, 32'h13);
        wt(13, 1'b0, 4);
        set_f <= 16'd5000;
        wt(0, 1'b0, 10);
        chk(trip, 32'h0);
        rdc(12'h0c0, 32'h1);
        rdc(12'h0d0, 32'h1);
        rdc(12'h01c, 32'h11);
        apb(1'b0, 12'h108, 32'h0);
        chk(rd[29:16], 32'h64);
        rdc(12'h100, 32'h1388);
        rdc(12'h104, 32'h64);
        apb(1'b1, 12'h000, 32'h1102);
        rdc(12'h0d0, 32'h0);
        set_f <= 16'd4900;
        wt(2, 1'b1, 20);
        @(posedge mclk_in);
        chk(start, 32'hd);
        set_u <= 8'd5;
        wt(10, 1'b1, 20);
        repeat (2) @(posedge mclk_in);
        chk({start, blocked}, 32'h0d);
        set_u <= 8'd100;
        repeat (20) @(posedge mclk_in);
        chk(blocked, 32'hd);
        set_f <= 16'd5050;
        set_v <= 2'b10;
        wt(10, 1'b0, 20);
        rdc(12'h010, 32'h000013ba);
        set_v <= 2'b00;
        repeat (8) @(posedge mclk_in);
        rdc(12'h010, 32'h000113ba);
        set_v <= 2'b11;
        set_f <= 16'd5000;
        for (int s = 0; s < 5; s++) begin
            apb(1'b1, 12'h004, 32'h9 | (s << 4));
            sel <= (s == 0) ? 32'hffffffff : 32'h1 << (8 * (s - 1));
            repeat (6) @(posedge mclk_in);
            chk(bank, (s == 0) ? 32'h1 : 32'h2);
            sel <= 32'h0;
            repeat (6) @(posedge mclk_in);
            chk(bank, 32'h1);
        end
        apb(1'b1, 12'h000, 32'h1);
        wt(12, 1'b1, 5);
        apb(1'b1, 12'h00c, 32'h6);
        wt(4, 1'b1, 5);
        wt(12, 1'b0, 400);
        wt(4, 1'b0, 5);
        results();
    end
endmodule
